// ---- logic/ddbc_pkg.sv ----
// Shared constants and types for the display DRAM bank configuration controller.
// Assumes a single 125 MHz clock and asynchronous 16-bit DRAMs on the far side.
package ddbc_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int DATA_W = 64;
    localparam int LANES = 8;
    localparam int ADDR_W = 22;
    localparam int MA_W = 9;
    localparam int CNT_W = 4;

    // ------------------------------------------------------------------
    // Capacity
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ONE_MB_BYTES = 22'h100000;
    localparam logic [ADDR_W-1:0] TWO_MB_BYTES = 22'h200000;
    localparam logic [2:0] CAP_MAX_MB = 3'h4;

    // ------------------------------------------------------------------
    // Access timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int T_RCD_NS = 24;
    localparam int T_CAS_NS = 40;
    localparam int T_RP_NS = 40;
    localparam int RCD_CYC = (T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CAS_CYC = (T_CAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RP_CYC = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_CYC = 2;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [MA_W-1:0] MA_RESET = 9'h000;
    localparam logic [LANES-1:0] LANES_IDLE_N = 8'hff;
    localparam logic [DATA_W-1:0] DATA_RESET = 64'h0;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ROW,
        ST_COL,
        ST_SYNC,
        ST_PRE
    } ddbc_state_t;

endpackage : ddbc_pkg

// ---- logic/ddbc_cfg_if.sv ----
// Decoded memory arrangement passed from the configuration decoder to the controller.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface ddbc_cfg_if;
    logic legal;
    logic wide64;
    logic first_b;
    logic first_2m;
    logic second_en;
    logic first_deep;
    logic second_deep;
    logic [2:0] total_mb;

    modport src (output legal, wide64, first_b, first_2m, second_en, first_deep,
        second_deep, total_mb);
    modport dst (input legal, wide64, first_b, first_2m, second_en, first_deep,
        second_deep, total_mb);
endinterface : ddbc_cfg_if

// ---- logic/ddbc_cfg_decode.sv ----
// Turns the three arrangement bits and the bus width into bank layout and capacity.
// Assumes the configuration bits come from logic on the same clock.
`timescale 1ns/10ps
module ddbc_cfg_decode (
    // Arrangement bits
    input wire logic second_bank_present_i,
    input wire logic one_mbyte_bank_select_i,
    input wire logic bank_order_swap_i,
    input wire logic bus_width_64_i,
    // Decoded layout
    ddbc_cfg_if.src cfg
);

    always_comb begin
        cfg.legal = 1'b0;
        cfg.wide64 = 1'b0;
        cfg.first_b = 1'b0;
        cfg.second_en = 1'b0;
        cfg.first_deep = 1'b0;
        cfg.second_deep = 1'b0;
        cfg.total_mb = 3'h0;
        unique case ({second_bank_present_i, one_mbyte_bank_select_i, bank_order_swap_i,
                bus_width_64_i})
            4'b0000: begin
                cfg.legal = 1'b1;
                cfg.first_deep = 1'b1;
                cfg.total_mb = 3'h1;
            end
            4'b0001: begin
                cfg.legal = 1'b1;
                cfg.wide64 = 1'b1;
                cfg.first_deep = 1'b1;
                cfg.total_mb = 3'h2;
            end
            4'b0101: begin
                cfg.legal = 1'b1;
                cfg.wide64 = 1'b1;
                cfg.total_mb = 3'h1;
            end
            4'b1001: begin
                cfg.legal = 1'b1;
                cfg.wide64 = 1'b1;
                cfg.second_en = 1'b1;
                cfg.first_deep = 1'b1;
                cfg.second_deep = 1'b1;
                cfg.total_mb = 3'h4;
            end
            4'b1011: begin
                cfg.legal = 1'b1;
                cfg.wide64 = 1'b1;
                cfg.second_en = 1'b1;
                cfg.first_b = 1'b1;
                cfg.first_deep = 1'b1;
                cfg.total_mb = 3'h3;
            end
            4'b1101: begin
                cfg.legal = 1'b1;
                cfg.wide64 = 1'b1;
                cfg.second_en = 1'b1;
                cfg.total_mb = 3'h2;
            end
            default: begin
                cfg.legal = 1'b0;
            end
        endcase
    end

    assign cfg.first_2m = cfg.wide64 & cfg.first_deep;

endmodule : ddbc_cfg_decode

// ---- logic/ddbc_lane_map.sv ----
// Places user bytes onto the byte lanes of the frame data bus and back.
// Assumes lane n of the bus is qualified by column strobe n.
`timescale 1ns/10ps
module ddbc_lane_map (
    // Mode
    input wire logic wide64_i,
    // User side
    input wire logic [7:0] be_i,
    input wire logic [63:0] wdata_i,
    output logic [63:0] rdata_o,
    // Bus side
    input wire logic [63:0] bus_rdata_i,
    output logic [7:0] lane_en_o,
    output logic [63:0] lane_wdata_o
);

    // Narrow mode runs on the upper four lanes only
    always_comb begin
        if (wide64_i) begin
            lane_en_o = be_i;
            lane_wdata_o = wdata_i;
            rdata_o = bus_rdata_i;
        end else begin
            lane_en_o = {be_i[3:0], 4'h0};
            lane_wdata_o = {wdata_i[31:0], 32'h0};
            rdata_o = {32'h0, bus_rdata_i[63:32]};
        end
    end

endmodule : ddbc_lane_map

// ---- logic/ddbc_top.sv ----
// Frame-buffer DRAM controller: bank decode, row/column strobes and byte lanes.
// Assumes 16-bit two-strobe DRAMs; the data bus pin level is resolved outside.
`timescale 1ns/10ps

// Functional notes
// - Capacity from 1 to 4 Mbytes using 128K-deep or 256K-deep parts.
// - All bits clear, 32-bit: 1 Mbyte, two devices on bank A, upper lanes.
// - Narrow arrangement uses only upper four byte lanes and their strobes.
// - All bits clear, 64-bit: 2 Mbytes, four devices on bank A.
// - Second bank only: 4 Mbytes, four devices per row strobe.
// - 1-Mbyte banks only: 1 Mbyte of 128K parts on bank A, 64 bits.
// - Second bank and 1-Mbyte banks: 2 Mbytes, 128K parts split per strobe.
// - Bank swap puts 256K bank B lowest, 3 Mbytes; with 1-Mbyte banks illegal.
// - Column strobe n qualifies exactly byte lane n of the data bus.
// - One shared 9-bit address and one write enable; output enable held active.
module ddbc_top (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // Arrangement bits
    input wire logic second_bank_present_i,
    input wire logic one_mbyte_bank_select_i,
    input wire logic bank_order_swap_i,
    input wire logic bus_width_64_i,
    // Arrangement status
    output logic cfg_legal_o,
    output logic cfg_bus_64_o,
    output logic [2:0] cfg_capacity_mb_o,
    // Access request
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [21:0] req_addr_i,
    input wire logic [7:0] req_be_i,
    input wire logic [63:0] req_wdata_i,
    output logic req_ready_o,
    // Access answer
    output logic rsp_valid_o,
    output logic rsp_err_o,
    output logic [63:0] rsp_rdata_o,
    // DRAM pins
    output logic row_strobe_bank_a_n_o,
    output logic row_strobe_bank_b_n_o,
    output logic [7:0] col_strobe_lane_n_o,
    output logic [8:0] dram_mux_addr_o,
    output logic dram_we_n_o,
    output logic dram_oe_n_o,
    input wire logic [63:0] frame_data_bus_i,
    output logic [63:0] frame_data_bus_o,
    output logic frame_data_bus_oe_n_o
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    ddbc_cfg_if cfg ();
    ddbc_pkg::ddbc_state_t state_reg;
    ddbc_pkg::ddbc_state_t state_next;
    logic [ddbc_pkg::CNT_W-1:0] cnt_reg;
    logic [63:0] sync1_reg;
    logic [63:0] sync2_reg;
    logic write_reg;
    logic bank_b_reg;
    logic [8:0] row_reg;
    logic [8:0] col_reg;
    logic [7:0] lane_en_reg;
    logic [63:0] wdata_reg;
    logic take;
    logic in_range;
    logic addr_ok;
    logic take_good;
    logic hit_first;
    logic hit_deep;
    logic hit_bank_b;
    logic [21:0] off_addr;
    logic [17:0] dev_word;
    logic [8:0] dec_row;
    logic [8:0] dec_col;
    logic [7:0] map_lane_en;
    logic [63:0] map_wdata;
    logic [63:0] map_rdata;
    logic cur_bank_b;
    logic cur_write;
    logic [7:0] cur_lane_en;
    logic [63:0] cur_wdata;
    logic ras_next;
    logic cas_next;

    // ------------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------------
    ddbc_cfg_decode u_cfg_decode (
        .second_bank_present_i(second_bank_present_i),
        .one_mbyte_bank_select_i(one_mbyte_bank_select_i),
        .bank_order_swap_i(bank_order_swap_i),
        .bus_width_64_i(bus_width_64_i),
        .cfg(cfg.src)
    );

    ddbc_lane_map u_lane_map (
        .wide64_i(cfg.wide64),
        .be_i(req_be_i),
        .wdata_i(req_wdata_i),
        .rdata_o(map_rdata),
        .bus_rdata_i(sync2_reg),
        .lane_en_o(map_lane_en),
        .lane_wdata_o(map_wdata)
    );

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    assign take = req_valid_i & req_ready_o;
    assign in_range = {1'b0, req_addr_i[21:20]} < cfg.total_mb;
    assign addr_ok = cfg.legal & in_range;
    assign take_good = take & addr_ok;
    assign hit_first = cfg.first_2m ? ~req_addr_i[21] : (req_addr_i[21:20] == 2'h0);
    assign hit_bank_b = (hit_first == cfg.first_b);
    assign hit_deep = hit_first ? cfg.first_deep : cfg.second_deep;
    assign off_addr = hit_first ? req_addr_i :
        (req_addr_i - (cfg.first_2m ? ddbc_pkg::TWO_MB_BYTES : ddbc_pkg::ONE_MB_BYTES));
    assign dev_word = cfg.wide64 ? off_addr[20:3] : off_addr[19:2];
    assign dec_row = hit_deep ? dev_word[17:9] : dev_word[16:8];
    assign dec_col = hit_deep ? dev_word[8:0] : {1'b0, dev_word[7:0]};

    assign cur_bank_b = take_good ? hit_bank_b : bank_b_reg;
    assign cur_write = take_good ? req_write_i : write_reg;
    assign cur_lane_en = take_good ? map_lane_en : lane_en_reg;
    assign cur_wdata = take_good ? map_wdata : wdata_reg;
    assign ras_next = (state_next == ddbc_pkg::ST_ROW) | (state_next == ddbc_pkg::ST_COL) |
        (state_next == ddbc_pkg::ST_SYNC);
    assign cas_next = (state_next == ddbc_pkg::ST_COL) | (state_next == ddbc_pkg::ST_SYNC);

    // ------------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ddbc_pkg::ST_IDLE: begin
                if (take_good) begin
                    state_next = ddbc_pkg::ST_ROW;
                end
            end
            ddbc_pkg::ST_ROW: begin
                if (cnt_reg == '0) begin
                    state_next = ddbc_pkg::ST_COL;
                end
            end
            ddbc_pkg::ST_COL: begin
                if (cnt_reg == '0) begin
                    state_next = write_reg ? ddbc_pkg::ST_PRE : ddbc_pkg::ST_SYNC;
                end
            end
            ddbc_pkg::ST_SYNC: begin
                if (cnt_reg == '0) begin
                    state_next = ddbc_pkg::ST_PRE;
                end
            end
            ddbc_pkg::ST_PRE: begin
                if (cnt_reg == '0) begin
                    state_next = ddbc_pkg::ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            state_reg <= ddbc_pkg::ST_IDLE;
            cnt_reg <= '0;
        end else begin
            state_reg <= state_next;
            if (state_next != state_reg) begin
                unique case (state_next)
                    ddbc_pkg::ST_ROW: cnt_reg <= ddbc_pkg::CNT_W'(ddbc_pkg::RCD_CYC - 1);
                    ddbc_pkg::ST_COL: cnt_reg <= ddbc_pkg::CNT_W'(ddbc_pkg::CAS_CYC - 1);
                    ddbc_pkg::ST_SYNC: cnt_reg <= ddbc_pkg::CNT_W'(ddbc_pkg::SYNC_CYC - 1);
                    ddbc_pkg::ST_PRE: cnt_reg <= ddbc_pkg::CNT_W'(ddbc_pkg::RP_CYC - 1);
                    ddbc_pkg::ST_IDLE: cnt_reg <= '0;
                endcase
            end else if (cnt_reg != '0) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end

    // Request held for the whole access
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            write_reg <= 1'b0;
            bank_b_reg <= 1'b0;
            row_reg <= ddbc_pkg::MA_RESET;
            col_reg <= ddbc_pkg::MA_RESET;
            lane_en_reg <= 8'h00;
            wdata_reg <= ddbc_pkg::DATA_RESET;
        end else if (take_good) begin
            write_reg <= req_write_i;
            bank_b_reg <= hit_bank_b;
            row_reg <= dec_row;
            col_reg <= dec_col;
            lane_en_reg <= map_lane_en;
            wdata_reg <= map_wdata;
        end
    end

    // ------------------------------------------------------------------
    // DRAM pins
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            row_strobe_bank_a_n_o <= 1'b1;
            row_strobe_bank_b_n_o <= 1'b1;
            col_strobe_lane_n_o <= ddbc_pkg::LANES_IDLE_N;
            dram_mux_addr_o <= ddbc_pkg::MA_RESET;
            dram_we_n_o <= 1'b1;
            dram_oe_n_o <= 1'b0;
            frame_data_bus_o <= ddbc_pkg::DATA_RESET;
            frame_data_bus_oe_n_o <= 1'b1;
        end else begin
            row_strobe_bank_a_n_o <= ~(ras_next & ~cur_bank_b);
            row_strobe_bank_b_n_o <= ~(ras_next & cur_bank_b);
            col_strobe_lane_n_o <= cas_next ? ~cur_lane_en : ddbc_pkg::LANES_IDLE_N;
            if (take_good) begin
                dram_mux_addr_o <= dec_row;
            end else if (state_next == ddbc_pkg::ST_COL && state_reg == ddbc_pkg::ST_ROW) begin
                dram_mux_addr_o <= col_reg;
            end
            dram_we_n_o <= ~(ras_next & cur_write);
            dram_oe_n_o <= 1'b0;
            frame_data_bus_o <= cur_wdata;
            frame_data_bus_oe_n_o <= ~(ras_next & cur_write);
        end
    end

    // Read data from the pins crosses two flops before use
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            sync1_reg <= ddbc_pkg::DATA_RESET;
            sync2_reg <= ddbc_pkg::DATA_RESET;
        end else begin
            sync1_reg <= frame_data_bus_i;
            sync2_reg <= sync1_reg;
        end
    end

    // ------------------------------------------------------------------
    // Answer and status
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            req_ready_o <= 1'b0;
            rsp_valid_o <= 1'b0;
            rsp_err_o <= 1'b0;
            rsp_rdata_o <= ddbc_pkg::DATA_RESET;
        end else begin
            req_ready_o <= (state_next == ddbc_pkg::ST_IDLE);
            rsp_valid_o <= 1'b0;
            rsp_err_o <= 1'b0;
            if (take && !addr_ok) begin
                rsp_valid_o <= 1'b1;
                rsp_err_o <= 1'b1;
                rsp_rdata_o <= ddbc_pkg::DATA_RESET;
            end else if (state_reg == ddbc_pkg::ST_COL && state_next == ddbc_pkg::ST_PRE) begin
                rsp_valid_o <= 1'b1;
            end else if (state_reg == ddbc_pkg::ST_SYNC && state_next == ddbc_pkg::ST_PRE) begin
                rsp_valid_o <= 1'b1;
                rsp_rdata_o <= map_rdata;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            cfg_legal_o <= 1'b0;
            cfg_bus_64_o <= 1'b0;
            cfg_capacity_mb_o <= 3'h0;
        end else begin
            cfg_legal_o <= cfg.legal;
            cfg_bus_64_o <= cfg.wide64;
            cfg_capacity_mb_o <= cfg.total_mb;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    localparam int ROW_DLY = ddbc_pkg::RCD_CYC;

    a_cap_bounds: assert property (@(posedge clock_i) disable iff (!rstn_i)
        cfg_legal_o |-> (cfg_capacity_mb_o >= 3'h1 && cfg_capacity_mb_o <= ddbc_pkg::CAP_MAX_MB))
        else $error("capacity out of range");
    a_narrow_one_mb: assert property (@(posedge clock_i) disable iff (!rstn_i)
        ($past(rstn_i) && $past(cfg.legal) && !$past(bus_width_64_i))
        |-> (cfg_capacity_mb_o == 3'h1))
        else $error("narrow arrangement not 1 Mbyte");
    a_narrow_lanes: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (take_good && !cfg.wide64) |=> (col_strobe_lane_n_o[3:0] == 4'hf) [*8])
        else $error("low lane strobe in narrow mode");
    a_first_bank_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (take_good && hit_first && !cfg.first_b)
        |=> !row_strobe_bank_a_n_o && row_strobe_bank_b_n_o)
        else $error("first bank not on bank A strobe");
    a_ras_exclusive: assert property (@(posedge clock_i) disable iff (!rstn_i)
        !(!row_strobe_bank_a_n_o && !row_strobe_bank_b_n_o))
        else $error("both row strobes active");
    a_one_mb_banks: assert property (@(posedge clock_i) disable iff (!rstn_i)
        ($past(one_mbyte_bank_select_i) && !$past(second_bank_present_i) && $past(cfg.legal))
        |-> (cfg_capacity_mb_o == 3'h1 && cfg_bus_64_o))
        else $error("1-Mbyte bank arrangement wrong");
    a_split_banks: assert property (@(posedge clock_i) disable iff (!rstn_i)
        ($past(one_mbyte_bank_select_i) && $past(second_bank_present_i) && $past(cfg.legal))
        |-> cfg_capacity_mb_o == 3'h2)
        else $error("split 128K banks not 2 Mbytes");
    a_swap_low: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (take_good && cfg.first_b && !req_addr_i[21]) |=> !row_strobe_bank_b_n_o)
        else $error("swapped low region not on bank B");
    a_swap_illegal: assert property (@(posedge clock_i) disable iff (!rstn_i)
        ($past(bank_order_swap_i) && $past(one_mbyte_bank_select_i)) |-> !cfg_legal_o)
        else $error("swap with 1-Mbyte banks accepted");
    a_lane_strobe: assert property (@(posedge clock_i) disable iff (!rstn_i)
        take_good |-> ##(ROW_DLY+1) (col_strobe_lane_n_o == ~$past(lane_en_reg, 1)))
        else $error("column strobes do not match byte lanes");
    a_addr_stable: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (state_reg == ddbc_pkg::ST_ROW && $past(state_reg) == ddbc_pkg::ST_ROW)
        |-> $stable(dram_mux_addr_o) && !dram_oe_n_o)
        else $error("row address moved or output enable released");
    a_range_ignored: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (take && !in_range) |=> rsp_valid_o && rsp_err_o && row_strobe_bank_a_n_o
        && row_strobe_bank_b_n_o)
        else $error("out-of-range access not ignored");

endmodule : ddbc_top

// ---- sim/ddbc_dram_model.sv ----
// Behavioural pair of DRAM banks behind the row and column strobes.
// Assumes registered strobes from the controller on the same clock.
`timescale 1ns/10ps
module ddbc_dram_model (
    // Clock
    input wire logic clock_i,
    // Strobes and address
    input wire logic ras_a_n_i,
    input wire logic ras_b_n_i,
    input wire logic [7:0] cas_n_i,
    input wire logic [8:0] addr_i,
    input wire logic we_n_i,
    // Data
    input wire logic [63:0] wdata_i,
    output logic [63:0] rdata_o
);
    logic [63:0] mem [logic [18:0]];
    logic [8:0] row_a = 9'h000;
    logic [8:0] row_b = 9'h000;
    logic [8:0] col = 9'h000;
    logic bank_b = 1'b0;
    logic ra_q = 1'b1;
    logic rb_q = 1'b1;
    logic cas_q = 1'b1;
    logic [63:0] last = 64'h0;
    logic [63:0] word;
    logic [18:0] key;
    assign key = {bank_b, bank_b ? row_b : row_a, col};
    // Released bus shows the inverse of its last value
    always @* begin
        rdata_o = ~last;
        if (cas_n_i != 8'hff && we_n_i && mem.exists(key)) rdata_o = mem[key];
    end
    always @(posedge clock_i) begin
        ra_q <= ras_a_n_i;
        rb_q <= ras_b_n_i;
        cas_q <= &cas_n_i;
        last <= rdata_o;
        if (!ras_a_n_i && ra_q) begin
            row_a <= addr_i;
            bank_b <= 1'b0;
        end
        if (!ras_b_n_i && rb_q) begin
            row_b <= addr_i;
            bank_b <= 1'b1;
        end
        if (!(&cas_n_i) && cas_q) col <= addr_i;
        if (!(&cas_n_i) && !cas_q && !we_n_i) begin
            word = mem.exists(key) ? mem[key] : 64'h0;
            for (int l = 0; l < 8; l++) if (!cas_n_i[l]) word[8*l+:8] = wdata_i[8*l+:8];
            mem[key] = word;
        end
    end
endmodule : ddbc_dram_model

// ---- sim/ddbc_top_tb.sv ----
// Self-checking bench for the frame-buffer DRAM controller.
// Assumes the DRAM model on the pins and a 125 MHz clock.
`timescale 1ns/10ps
module ddbc_top_tb;
    typedef struct packed {
        logic err;
        logic rd;
        logic [1:0] bank;
        logic [7:0] lanes;
        logic [63:0] data;
    } ddbc_exp_t;
    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [3:0] cfg = 4'h0;
    logic vld = 1'b0;
    logic wr = 1'b0;
    logic [21:0] adr = 22'h0;
    logic [7:0] ben = 8'h0;
    logic [63:0] wd = 64'h0;
    logic [63:0] pin, bus_o, mdl, rdata;
    logic ready, rsp_valid, rsp_err, ras_a_n, ras_b_n, we_n, oe_n, legal, bus64, drv_n;
    logic [2:0] cap;
    logic [7:0] cas_n;
    logic [7:0] lanes_seen = 8'h0;
    logic [8:0] ma;
    logic [1:0] bank_seen = 2'h0;
    int err_count = 0;
    int comparisons = 0;
    int cyc = 0;
    ddbc_exp_t expq [$];
    ddbc_exp_t e;
    assign pin = drv_n ? mdl : bus_o;
    ddbc_top i_dut (.clock_i(clock_i), .rstn_i(rstn_i), .second_bank_present_i(cfg[3]),
        .one_mbyte_bank_select_i(cfg[2]), .bank_order_swap_i(cfg[1]), .bus_width_64_i(cfg[0]),
        .cfg_legal_o(legal), .cfg_bus_64_o(bus64), .cfg_capacity_mb_o(cap),
        .req_valid_i(vld), .req_write_i(wr), .req_addr_i(adr), .req_be_i(ben),
        .req_wdata_i(wd), .req_ready_o(ready), .rsp_valid_o(rsp_valid), .rsp_err_o(rsp_err),
        .rsp_rdata_o(rdata), .row_strobe_bank_a_n_o(ras_a_n), .row_strobe_bank_b_n_o(ras_b_n),
        .col_strobe_lane_n_o(cas_n), .dram_mux_addr_o(ma), .dram_we_n_o(we_n),
        .dram_oe_n_o(oe_n), .frame_data_bus_i(pin), .frame_data_bus_o(bus_o),
        .frame_data_bus_oe_n_o(drv_n));
    ddbc_dram_model i_dram (.clock_i(clock_i), .ras_a_n_i(ras_a_n), .ras_b_n_i(ras_b_n),
        .cas_n_i(cas_n), .addr_i(ma), .we_n_i(we_n), .wdata_i(pin), .rdata_o(mdl));
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wrap_up;
        if (err_count == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : wrap_up
    task automatic access(input logic w, input logic [21:0] a, input logic [7:0] b,
        input logic [63:0] d, input ddbc_exp_t x);
        @(negedge clock_i);
        vld = 1'b1;
        wr = w;
        adr = a;
        ben = b;
        wd = d;
        while (ready !== 1'b1 && cyc < 20000) @(negedge clock_i);
        @(posedge clock_i);
        expq.push_back(x);
    endtask : access
    function automatic logic [2:0] cap_of(input logic [3:0] k);
        case (k)
            4'h0, 4'h5: return 3'h1;
            4'h1, 4'hd: return 3'h2;
            4'h9: return 3'h4;
            4'hb: return 3'h3;
            default: return 3'h0;
        endcase
    endfunction : cap_of
    initial forever #4 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            wrap_up();
        end
    end
    // Strobes seen since the last answer are judged with it
    always @(negedge clock_i) begin
        lanes_seen = lanes_seen | ~cas_n;
        bank_seen = bank_seen | {~ras_b_n, ~ras_a_n};
        if (rsp_valid === 1'b1) begin
            e = expq.pop_front();
            chk("rsp_err", e.err, rsp_err);
            chk("row_strobe", e.bank, bank_seen);
            chk("col_strobe", e.lanes, lanes_seen);
            chk("dram_oe_n", 1'b0, oe_n);
            if (e.rd) chk("rsp_rdata", e.data, rdata);
            lanes_seen = 8'h0;
            bank_seen = 2'h0;
        end
    end
    initial begin
        logic [2:0] c;
        logic [21:0] fsz, a;
        logic [63:0] d1, d2, m;
        logic [7:0] be, bm, lm;
        logic [1:0] bk;
        void'($urandom(2));
        repeat (20) @(negedge clock_i);
        rstn_i = 1'b1;
        for (int k = 0; k < 16; k++) begin
            cfg = k[3:0];
            repeat (2) @(negedge clock_i);
            c = cap_of(cfg);
            chk("legal", c != 3'h0, legal);
            chk("capacity", c, cap);
            if (c != 3'h0) chk("bus64", cfg[0], bus64);
            fsz = (cfg[0] && !cfg[2]) ? 22'h200000 : 22'h100000;
            bm = cfg[0] ? 8'hff : 8'hf0;
            for (int n = 0; n < 4 && c != 3'h0; n++) begin
                a = (n == 0) ? 22'({c, 20'h0} - 23'h8) : (n == 1) ? 22'h0 :
                    22'($urandom % {c, 20'h0});
                a[2:0] = 3'h0;
                bk = ((a < fsz) ^ cfg[1]) ? 2'h1 : 2'h2;
                d1 = {$urandom, $urandom};
                access(1'b1, a, 8'hff, d1, '{1'b0, 1'b0, bk, bm, 64'h0});
                d2 = {$urandom, $urandom};
                be = 8'($urandom);
                m = d1;
                for (int l = 0; l < 8; l++) if (be[l]) m[8*l+:8] = d2[8*l+:8];
                lm = cfg[0] ? be : {be[3:0], 4'h0};
                access(1'b1, a, be, d2, '{1'b0, 1'b0, bk, lm, 64'h0});
                if (!cfg[0]) m = {32'h0, m[31:0]};
                access(1'b0, a, 8'hff, 64'h0, '{1'b0, 1'b1, bk, bm, m});
            end
            if (c != 3'h4) begin
                a = (c == 3'h0) ? 22'h0 : {c[1:0], 20'h0};
                access(1'b0, a, 8'hff, 64'h0, '{1'b1, 1'b1, 2'h0, 8'h0, 64'h0});
                access(1'b1, a, 8'hff, 64'h0, '{1'b1, 1'b0, 2'h0, 8'h0, 64'h0});
            end
            @(negedge clock_i);
            vld = 1'b0;
            repeat (40) if (expq.size() != 0 || ready !== 1'b1) @(negedge clock_i);
        end
        chk("pending", 64'h0, 64'(expq.size()));
        wrap_up();
    end
endmodule : ddbc_top_tb
